// >>> core/tcrw_chan_mem.sv
`timescale 1ns/1ps
// Per-channel reading store with registered read data
module tcrw_chan_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Write port
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // Read port
  input wire logic i_re,
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  // Entries reset to zero so a channel never converted reads back all-clear, not unknown
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        mem_ff[e] <= '0;
      end else if (i_we && (i_waddr == AW'(e))) begin
        mem_ff[e] <= i_wdata;
      end
    end
  end

  // Read data leaves through a register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_re) begin
      o_rdata <= mem_ff[i_raddr];
    end
  end

endmodule : tcrw_chan_mem

// >>> core/tcrw_fifo.sv
`timescale 1ns/1ps
// Small synchronous FIFO with valid/ready on both sides
module tcrw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // Honest full and empty straight from the count
  assign o_in_ready = (count_ff != (AW+1)'(DEPTH));
  assign o_out_valid = (count_ff != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_ff[rd_ptr_ff];

  // Storage has no reset; entries are only read once written
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= i_in_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop) count_ff <= count_ff + 1'b1;
      else if (pop && !push) count_ff <= count_ff - 1'b1;
    end
  end

endmodule : tcrw_fifo

// >>> core/tcrw_formatter.sv
`timescale 1ns/1ps
// Function
// - Lowest three word bits carry the channel index zero to seven.
// - Bit 9 is high for a valid reading, low otherwise.
// - Bit 11 is high when the channel input is open.
// - Bit 12 is one for negative temperature, zero for positive.
// - Bit 13 is high while supply monitors report acceptable levels.
// - Bit 14 flags input at or below the bottom of range.
// - Bit 15 flags input at or above the top of range.
// - Bit 16 toggles each time a channel conversion finishes.
// - Twelve-bit temperature sits in word bits 17 through 28.
// - Bits 29 to 32 copy the sign in two's complement, else zero; a negative zero leaves them zero.
// - Reading plus extension form a 16-bit value, format chosen by setting.
// - Two's complement negates by inverting every bit then adding one.
// - Word bit 1 maps to the group's lowest input, bit 32 highest.
// - Group start decodes from switches three to seven in steps of 32.
// - Each word moves over four consecutive addresses, one byte each.
// - After a word is read the next channel is selected automatically.
module tcrw_formatter (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Conversion results from the measuring engine
  input wire logic i_conv_valid,
  output logic o_conv_ready,
  input wire tcrw_pkg::tcrw_conv_t i_conv,
  // Pins: supply monitor, format jumper, backplane switches 3..7
  input wire logic i_supply_ok,
  input wire logic i_twos_sel,
  input wire logic [tcrw_pkg::SW_W-1:0] i_group_sw,
  // I/O bus byte reads
  input wire logic i_io_rd,
  input wire logic [1:0] i_io_addr,
  output logic o_io_ack,
  output logic [tcrw_pkg::BYTE_W-1:0] o_io_data,
  // Status
  output logic [tcrw_pkg::GROUP_W-1:0] o_group_start,
  output logic [tcrw_pkg::CH_W-1:0] o_cur_chan
);
  import tcrw_pkg::*;

  localparam int RD_W = $bits(tcrw_reading_t);
  localparam int CONV_W = $bits(tcrw_conv_t);
  localparam int PIN_W = SW_W + 2;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_sync_ff;
  logic supply_s;
  logic twos_s;
  logic [SW_W-1:0] sw_s;
  logic fifo_valid;
  logic fifo_ready;
  tcrw_conv_t fifo_data;
  logic wr_en;
  logic beat_ff;
  logic [NUM_CH-1:0] seen_ff;
  logic [CH_W-1:0] cur_chan_ff;
  logic [CH_W-1:0] nxt_chan;
  logic load_req;
  logic pend_ff;
  logic [1:0] pend_addr_ff;
  logic [RD_W-1:0] rdata;
  tcrw_reading_t rd_q;
  logic [WORD_W-1:0] word_ff;
  logic [WORD_W-1:0] nxt_word;
  logic [WORD_W-1:0] fmt_word;
  logic [VAL_W-1:0] value;
  logic ack_ff;
  logic [BYTE_W-1:0] data_ff;
  logic [GROUP_W-1:0] group_ff;
  logic advance;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: only the second stage is read
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= {i_supply_ok, i_twos_sel, i_group_sw};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign supply_s = pin_sync_ff[PIN_W-1];
  assign twos_s = pin_sync_ff[PIN_W-2];
  assign sw_s = pin_sync_ff[SW_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Group start: closed switches read zero, open switches 3 to 7 add 32, 64, 128, 256 and 512 inputs
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      group_ff <= GROUP_BASE;
    end else begin
      group_ff <= {sw_s, GROUP_SHIFT'(0)} + GROUP_BASE;
    end
  end

  assign o_group_start = group_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion results queue up so a busy reader never drops one
  tcrw_fifo #(
    .WIDTH(CONV_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_conv_valid),
    .o_in_ready(o_conv_ready),
    .i_in_data(i_conv),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_ready),
    .o_out_data(fifo_data)
  );

  // The store has one access per cycle; a word load takes priority
  assign load_req = i_io_rd && (i_io_addr == BYTE_FIRST);
  assign fifo_ready = !load_req;
  assign wr_en = fifo_valid && fifo_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Heartbeat flips once per finished conversion and is stored with it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      beat_ff <= RST_BEAT;
    end else if (wr_en) begin
      beat_ff <= !beat_ff;
    end
  end

  // Channels never converted since reset report invalid
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_ff <= '0;
    end else if (wr_en) begin
      seen_ff[fifo_data.chan] <= 1'b1;
    end
  end

  tcrw_chan_mem #(
    .WIDTH(RD_W),
    .DEPTH(NUM_CH)
  ) u_mem (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_we(wr_en),
    .i_waddr(fifo_data.chan),
    .i_wdata({fifo_data.rd.temp, fifo_data.rd.neg, fifo_data.rd.open,
              fifo_data.rd.under, fifo_data.rd.over, fifo_data.rd.ok, !beat_ff}),
    .i_re(load_req),
    .i_raddr(nxt_chan),
    .o_rdata(rdata)
  );

  assign rd_q = tcrw_reading_t'(rdata);

  ////////////////////////////////////////////////////////////////////////////
  // Channel pointer moves on once the last byte of a word is answered
  assign advance = pend_ff && (pend_addr_ff == BYTE_LAST);
  assign nxt_chan = advance ? cur_chan_ff + 1'b1 : cur_chan_ff;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_chan_ff <= RST_CHAN;
    end else begin
      cur_chan_ff <= nxt_chan;
    end
  end

  assign o_cur_chan = cur_chan_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Value formatting; a negative zero stays zero in both forms
  always_comb begin
    value = {{(VAL_W-TEMP_W){1'b0}}, rd_q.temp};
    if (twos_s && rd_q.neg) begin
      value = ~value + 1'b1;
    end
  end

  // Word assembly; bit 1 of the group is index 0 here
  always_comb begin
    fmt_word = RST_WORD;
    fmt_word[WB_CHAN_LO +: CH_W] = cur_chan_ff;
    fmt_word[WB_VALID] = seen_ff[cur_chan_ff] && rd_q.ok;
    fmt_word[WB_OPEN] = rd_q.open;
    fmt_word[WB_SIGN] = rd_q.neg;
    fmt_word[WB_SUPPLY] = supply_s;
    fmt_word[WB_UNDER] = rd_q.under;
    fmt_word[WB_OVER] = rd_q.over;
    fmt_word[WB_BEAT] = rd_q.beat;
    fmt_word[WB_DATA_LO +: TEMP_W] = value[TEMP_W-1:0];
    fmt_word[WB_EXT_LO +: (VAL_W-TEMP_W)] = value[VAL_W-1:TEMP_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read pipeline stage one: remember which byte was asked for
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_ff <= 1'b0;
      pend_addr_ff <= BYTE_FIRST;
    end else begin
      pend_ff <= i_io_rd;
      pend_addr_ff <= i_io_addr;
    end
  end

  // The first byte snapshots the word so later bytes stay coherent
  assign nxt_word = (pend_ff && pend_addr_ff == BYTE_FIRST) ? fmt_word : word_ff;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_ff <= RST_WORD;
    end else begin
      word_ff <= nxt_word;
    end
  end

  // Stage two: answer one byte per address, lowest bits first
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      ack_ff <= pend_ff;
      if (pend_ff) begin
        data_ff <= nxt_word[pend_addr_ff*BYTE_W +: BYTE_W];
      end
    end
  end

  assign o_io_ack = ack_ff;
  assign o_io_data = data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic load_q;
  logic [1:0] ack_addr_ff;
  logic [CH_W-1:0] load_chan_ff;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_q <= 1'b0;
      ack_addr_ff <= BYTE_FIRST;
      load_chan_ff <= RST_CHAN;
    end else begin
      load_q <= pend_ff && (pend_addr_ff == BYTE_FIRST);
      ack_addr_ff <= pend_addr_ff;
      if (pend_ff && pend_addr_ff == BYTE_FIRST) load_chan_ff <= cur_chan_ff;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_chan_byte:
    assert property (o_io_ack && ack_addr_ff == BYTE_FIRST |->
      o_io_data[CH_W-1:0] == load_chan_ff && word_ff[2:0] == load_chan_ff)
    else $error("Channel field does not match the channel read");

  a_unused_zero:
    assert property (load_q |-> word_ff[7:3] == 5'h00 && word_ff[9] == 1'b0)
    else $error("Unused word bits are not zero");

  a_valid_flag:
    assert property (load_q && !seen_ff[load_chan_ff] |-> !word_ff[WB_VALID])
    else $error("Never converted channel reported valid");

  a_supply_flag:
    assert property (pend_ff && pend_addr_ff == BYTE_FIRST |=>
      word_ff[WB_SUPPLY] == $past(supply_s))
    else $error("Supply flag does not follow the monitor");

  a_status_flags:
    assert property (pend_ff && pend_addr_ff == BYTE_FIRST |=>
      word_ff[WB_OVER:WB_UNDER] == {$past(rd_q.over), $past(rd_q.under)}
      && word_ff[WB_SIGN] == $past(rd_q.neg) && word_ff[WB_OPEN] == $past(rd_q.open))
    else $error("Status flags differ from the stored reading");

  a_beat_toggle:
    assert property (wr_en |=> beat_ff != $past(beat_ff) ##1 (beat_ff == $past(beat_ff)
      || $past(wr_en)))
    else $error("Heartbeat did not toggle once per conversion");

  a_twos_value:
    assert property (pend_ff && pend_addr_ff == BYTE_FIRST && twos_s && rd_q.neg |=>
      word_ff[31:16] + {4'h0, $past(rd_q.temp)} == 16'h0000)
    else $error("Two's complement value is not the negated magnitude");

  a_signmag_ext:
    assert property (pend_ff && pend_addr_ff == BYTE_FIRST && !twos_s |=>
      word_ff[31:16] == {4'h0, $past(rd_q.temp)})
    else $error("Sign-magnitude value or extension is wrong");

  a_chan_advance:
    assert property (o_io_ack && ack_addr_ff == BYTE_LAST |->
      cur_chan_ff == CH_W'($past(cur_chan_ff) + 1'b1))
    else $error("Channel did not advance after the last byte");

  a_group_base:
    assert property (##3 o_group_start == {$past(i_group_sw, 3), 5'h01})
    else $error("Group start does not follow the switches");

  a_load_stalls:
    assert property (load_req |-> !wr_en ##2 o_io_ack)
    else $error("Store written during a word load or no answer");

  // Positive readings in two's complement keep the plain magnitude
  a_pos_twos:
    assert property (pend_ff && pend_addr_ff == BYTE_FIRST && twos_s && !rd_q.neg |=>
      word_ff[31:16] == {4'h0, $past(rd_q.temp)})
    else $error("Positive two's complement value is wrong");

  a_beat_hold:
    assert property (!wr_en |=> beat_ff == $past(beat_ff))
    else $error("Heartbeat changed without a finished conversion");

  a_chan_hold:
    assert property (!advance |=> cur_chan_ff == $past(cur_chan_ff))
    else $error("Channel moved without a finished word");

  // Every byte request gets exactly one answer two edges later
  a_one_answer:
    assert property (i_io_rd |-> ##2 o_io_ack)
    else $error("Byte request not answered in time");

  a_byte_map:
    assert property (o_io_ack |-> o_io_data == word_ff[ack_addr_ff*BYTE_W +: BYTE_W])
    else $error("Answered byte is not the addressed slice of the word");

  a_valid_seen:
    assert property (load_q && word_ff[WB_VALID] |-> seen_ff[load_chan_ff])
    else $error("Valid flag set for a channel never converted");

  c_full_word: cover property (o_io_ack && ack_addr_ff == BYTE_LAST);
  c_unconverted: cover property (load_q && !seen_ff[load_chan_ff]);
  c_fifo_full: cover property (i_conv_valid && !o_conv_ready);
  c_neg_twos: cover property (load_q && twos_s && word_ff[WB_SIGN]);
  c_wrap: cover property (advance && cur_chan_ff == 3'h7);

endmodule : tcrw_formatter

// >>> include/tcrw_pkg.sv
// Shared constants and carriers for the reading word formatter
package tcrw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int CH_W = 3;
  localparam int NUM_CH = 8;
  localparam int TEMP_W = 12;
  localparam int VAL_W = 16;
  localparam int WORD_W = 32;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int SW_W = 5;
  localparam int GROUP_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Word field positions (word bit n sits at index n-1)
  localparam int WB_CHAN_LO = 0;
  localparam int WB_VALID = 8;
  localparam int WB_OPEN = 10;
  localparam int WB_SIGN = 11;
  localparam int WB_SUPPLY = 12;
  localparam int WB_UNDER = 13;
  localparam int WB_OVER = 14;
  localparam int WB_BEAT = 15;
  localparam int WB_DATA_LO = 16;
  localparam int WB_EXT_LO = 28;

  ////////////////////////////////////////////////////////////////////////////
  // Addresses, group decode and reset values
  localparam logic [1:0] BYTE_FIRST = 2'h0;
  localparam logic [1:0] BYTE_LAST = 2'h3;
  localparam int GROUP_SHIFT = 5;
  localparam logic [GROUP_W-1:0] GROUP_BASE = 10'h001;
  localparam logic [CH_W-1:0] RST_CHAN = 3'h0;
  localparam logic RST_BEAT = 1'b0;
  localparam logic [WORD_W-1:0] RST_WORD = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [TEMP_W-1:0] temp;  // Magnitude
    logic neg;
    logic open;
    logic under;
    logic over;
    logic ok;
    logic beat;
  } tcrw_reading_t;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    tcrw_reading_t rd;
  } tcrw_conv_t;

endpackage : tcrw_pkg

// >>> sim/tb_thermocouple_reading_word_formatter.sv
`timescale 1ns/1ps
module tb_thermocouple_reading_word_formatter;
  import tcrw_pkg::*;
  logic i_clock;
  logic i_rst_n;
  logic i_conv_valid;
  logic o_conv_ready;
  tcrw_conv_t i_conv;
  logic i_supply_ok;
  logic i_twos_sel;
  logic [4:0] i_group_sw;
  logic i_io_rd;
  logic [1:0] i_io_addr;
  logic o_io_ack;
  logic [7:0] o_io_data;
  logic [9:0] o_group_start;
  logic [2:0] o_cur_chan;
  int failures;
  int total_checks;
  tcrw_reading_t mdl_rd [8];
  int mdl_idx [8];
  int stored;
  int beat_ofs;
  int exp_ch;
  logic [31:0] w;
  logic [31:0] r;
  logic [4:0] sws [5];
  tcrw_conv_t c;

  tcrw_formatter tcrw_formatter_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_conv_valid(i_conv_valid), .o_conv_ready(o_conv_ready), .i_conv(i_conv),
    .i_supply_ok(i_supply_ok), .i_twos_sel(i_twos_sel), .i_group_sw(i_group_sw),
    .i_io_rd(i_io_rd), .i_io_addr(i_io_addr), .o_io_ack(o_io_ack),
    .o_io_data(o_io_data), .o_group_start(o_group_start), .o_cur_chan(o_cur_chan));

  tcrw_reader tcrw_reader_inst (.i_clock(i_clock), .i_io_ack(o_io_ack),
    .i_io_data(o_io_data), .o_io_rd(i_io_rd), .o_io_addr(i_io_addr));

  ////////////////////////////////////////
  // Clock, 10 ns period
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic miss(input string what);
    failures++;
    $display("mismatch t=%0t %s", $time, what);
  endtask : miss

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  // Model word; supply is live, heartbeat starts at its reset level and flips per store
  function automatic logic [31:0] exp_word(input int ch);
    logic [31:0] e;
    tcrw_reading_t m;
    m = mdl_rd[ch];
    e = 32'h0;
    e[2:0] = ch[2:0];
    e[WB_VALID] = (mdl_idx[ch] > 0) && m.ok;
    e[WB_OPEN] = m.open;
    e[WB_SIGN] = m.neg;
    e[WB_SUPPLY] = i_supply_ok;
    e[WB_UNDER] = m.under;
    e[WB_OVER] = m.over;
    e[WB_BEAT] = 1'(beat_ofs ^ (mdl_idx[ch] % 2));
    e[31:16] = {4'h0, m.temp};
    if (i_twos_sel && m.neg) begin
      e[31:16] = 16'(-int'(m.temp));
    end
    return e;
  endfunction : exp_word

  // Offer one result, hold it until the edge that takes it
  task automatic send_conv(input tcrw_conv_t cv);
    int n;
    @(negedge i_clock);
    i_conv_valid = 1'b1;
    i_conv = cv;
    n = 0;
    while (o_conv_ready !== 1'b1 && n < 50) begin
      @(negedge i_clock);
      n++;
    end
    if (n == 50) miss("result never taken");
    @(posedge i_clock);
    stored++;
    mdl_rd[cv.chan] = cv.rd;
    mdl_idx[cv.chan] = stored;
  endtask : send_conv

  task automatic conv_idle();
    @(negedge i_clock);
    i_conv_valid = 1'b0;
    i_conv = ~i_conv;
  endtask : conv_idle

  // Eight words per burst, one for each channel; strobe spacing is scaled down to keep the run short
  task automatic scan(input int gap);
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      i_supply_ok = r[0];
      repeat (4) @(negedge i_clock);
      chk_val(10'(o_cur_chan), 10'(exp_ch), "channel");
      tcrw_reader_inst.read_word(gap, w);
      chk_word(w, exp_word(exp_ch));
      exp_ch = (exp_ch + 1) % 8;
    end
  endtask : scan

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////
  // Watchdog: the run needs under a thousand cycles
  initial begin
    #300000;
    miss("watchdog expired");
    end_of_test();
  end

  ////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    i_conv_valid = 1'b0;
    i_conv = '0;
    i_supply_ok = 1'b1;
    i_twos_sel = 1'b0;
    i_group_sw = 5'h00;
    stored = 0;
    beat_ofs = int'(RST_BEAT);
    foreach (mdl_rd[i]) mdl_rd[i] = '0;
    exp_ch = 0;
    failures = 0;
    total_checks = 0;
    void'($urandom(41));
    repeat (20) @(negedge i_clock);
    chk_val({o_io_ack, o_io_data, o_conv_ready}, 10'h001, "reset outputs");
    chk_val({7'h00, o_cur_chan}, 10'h000, "reset channel");
    chk_val(o_group_start, 10'h001, "reset group start");
    i_rst_n = 1'b1;
    $display("test reset done");
    // Switch decode: none, switch 5, switch 6, all, random
    sws = '{5'h00, 5'h04, 5'h08, 5'h1f, 5'($urandom)};
    foreach (sws[i]) begin
      @(negedge i_clock);
      i_group_sw = sws[i];
      repeat (5) @(negedge i_clock);
      chk_val(o_group_start, 10'(int'(sws[i]) * 32 + 1), "group start");
    end
    $display("test group done");
    // A word read before any conversion must report invalid with clear data
    tcrw_reader_inst.read_word(0, w);
    chk_word(w, exp_word(exp_ch));
    exp_ch = 1;
    chk_val(10'(o_cur_chan), 10'h001, "channel after first word");
    $display("test unconverted done");
    // Both formats, prompt and slow reader
    for (int p = 0; p < 4; p++) begin
      i_twos_sel = p[0];
      for (int ch = 0; ch < 8; ch++) begin
        r = $urandom;
        c = r[20:0];
        c.chan = 3'(ch);
        send_conv(c);
      end
      conv_idle();
      repeat (8) @(negedge i_clock);
      scan(p / 2);
      $display("test format %0d done", p);
    end
    // Fill the buffer while the reader stalls the store side, then drain
    fork
      tcrw_reader_inst.hold_first(20);
      begin
        repeat (2) @(negedge i_clock);
        repeat (4) begin
          r = $urandom;
          send_conv(r[20:0]);
        end
        @(negedge i_clock);
        chk_val(10'(o_conv_ready), 10'h000, "ready when full");
        conv_idle();
      end
    join
    repeat (8) @(negedge i_clock);
    chk_val(10'(o_conv_ready), 10'h001, "ready after drain");
    scan(0);
    $display("test buffer done");
    end_of_test();
  end
endmodule : tb_thermocouple_reading_word_formatter

// >>> sim/tcrw_reader.sv
`timescale 1ns/1ps
// Scanning controller model: reads one channel word as four byte reads
module tcrw_reader (
  // Clock
  input wire logic i_clock,
  // Byte answers
  input wire logic i_io_ack,
  input wire logic [7:0] i_io_data,
  // Byte requests
  output logic o_io_rd,
  output logic [1:0] o_io_addr
);
  logic [7:0] bytes_q[$];

  initial begin
    o_io_rd = 1'b0;
    o_io_addr = 2'h0;
  end

  ////////////////////////////////////////
  // Keep every answered byte, sampled at the edge where ack is high
  always @(posedge i_clock) begin
    if (i_io_ack === 1'b1) begin
      bytes_q.push_back(i_io_data);
    end
  end

  // Idle address keeps moving so a stale value never looks like a request
  task automatic idle();
    @(negedge i_clock);
    o_io_rd = 1'b0;
    o_io_addr = ~o_io_addr;
  endtask : idle

  // Four consecutive addresses, lowest word bits first; gap makes a slow reader
  task automatic read_word(input int gap, output logic [31:0] word);
    int n;
    bytes_q.delete();
    word = 32'hxxxx_xxxx;
    for (int i = 0; i < 4; i++) begin
      repeat (gap) idle();
      @(negedge i_clock);
      o_io_rd = 1'b1;
      o_io_addr = 2'(i);
    end
    idle();
    n = 0;
    while (bytes_q.size() < 4 && n < 20) begin
      @(negedge i_clock);
      n++;
    end
    if (bytes_q.size() == 4) begin
      word = {bytes_q[3], bytes_q[2], bytes_q[1], bytes_q[0]};
    end
  endtask : read_word

  // Hold byte-0 reads for n cycles; this stalls the store side
  task automatic hold_first(input int n);
    repeat (n) begin
      @(negedge i_clock);
      o_io_rd = 1'b1;
      o_io_addr = 2'h0;
    end
    repeat (4) idle();
    bytes_q.delete();
  endtask : hold_first
endmodule : tcrw_reader
